//--- rtl/scv_params.svh
// Constants for the coincidence voter: counts, widths, reset values.
// Assumes inclusion by the voter package, the voter module and the bound property checker.
`ifndef SCV_PARAMS_SVH
`define SCV_PARAMS_SVH
`define SCV_NDIV        4
`define SCV_NVAR        8
`define SCV_VOTE_MIN    3'h2
`define SCV_RESET_NS    2000
`define SCV_CLK_NS      10
`define SCV_RESET_CYC   (`SCV_RESET_NS / `SCV_CLK_NS)
`define SCV_CNT_W       16
`define SCV_DIAG_W      16
`endif

//--- rtl/scv_pkg.sv
// Types for the coincidence voter.
// Assumes scv_params.svh is reachable by bare name.
`include "scv_params.svh"
package scv_pkg;
  // Per-division trip inputs: one bit per process variable.
  typedef logic [`SCV_NVAR-1:0] scv_var_t;
  // Status bundle for isolated indication outputs.
  typedef struct packed {
    logic [`SCV_NDIV-1:0] div_trip;
    logic                 man_a;
    logic                 man_b;
    logic                 full_scram;
    logic                 reset_ok;
    logic [1:0]           test_mode;
    logic [5:0]           spare;
  } scv_stat_t;
  // Operating mode selector position, one-hot.
  typedef enum logic [3:0] {
    SCV_MODE_SHUTDOWN = 4'h1,
    SCV_MODE_REFUEL   = 4'h2,
    SCV_MODE_STARTUP  = 4'h4,
    SCV_MODE_RUN      = 4'h8
  } scv_mode_t;
  // Reset sequencer states, one-hot.
  typedef enum logic [2:0] {
    SCV_ST_NORMAL  = 3'h1,
    SCV_ST_SEALED  = 3'h2,
    SCV_ST_RESETOK = 3'h4
  } scv_state_t;
  // Test selection.
  typedef enum logic [1:0] {
    SCV_TEST_NONE = 2'h0,
    SCV_TEST_CHAN = 2'h1,
    SCV_TEST_DIV  = 2'h2,
    SCV_TEST_SYS  = 2'h3
  } scv_test_t;
endpackage

//--- rtl/scv_voter.sv
// Coincidence voter with seal-in, delayed reset and isolated status.
// Assumes synchronous inputs; trip inputs are active high "trip", with a
// separate healthy bit per channel so a lost input reads as a trip.
// A partial division trip seals in and clears only with the next accepted reset.
// Solenoid outputs are high when energised; a scram drives them low.
// Out-of-service divisions are masked from their own trip and from the scram vote.
// Reset is refused while any live trip cause remains, even after the delay.
`timescale 1ns/100ps
`include "scv_params.svh"
module scv_voter (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire scv_pkg::scv_var_t [`SCV_NDIV-1:0] chan_trip,
  input  wire logic [`SCV_NDIV-1:0]         chan_healthy,
  input  wire logic [`SCV_NDIV-1:0]         chan_bypass,
  input  wire logic [`SCV_NDIV-1:0]         div_oos,
  input  wire scv_pkg::scv_var_t            var_permit,
  input  wire logic [3:0]                   mode_sel,
  input  wire logic                         man_sw_a,
  input  wire logic                         man_sw_b,
  input  wire logic                         oper_reset,
  input  wire logic [1:0]                   test_sel,
  input  wire logic [`SCV_NDIV-1:0]         test_inject,
  output logic [`SCV_NDIV-1:0]              div_trip_ff,
  output logic                              sol_a_energ_ff,
  output logic                              sol_b_energ_ff,
  output logic                              dump_valve_a_ff,
  output logic                              dump_valve_b_ff,
  output logic                              rod_runin_ff,
  output logic                              man_path_a_ff,
  output logic                              man_path_b_ff,
  output scv_pkg::scv_stat_t                status_ff
);

  // ********************************************************************
  // Voting functions
  // ********************************************************************
  // Counts the set inputs.
  function automatic logic [2:0] scv_count(input logic [`SCV_NDIV-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < `SCV_NDIV; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  // True for two or more set inputs; a bypassed input is forced low beforehand,
  // which turns two of four into two of three.
  function automatic logic scv_vote(input logic [`SCV_NDIV-1:0] v);
    return scv_count(v) >= `SCV_VOTE_MIN;
  endfunction

  // ********************************************************************
  // Channel conditioning and automatic divisions
  // ********************************************************************
  scv_pkg::scv_var_t [`SCV_NDIV-1:0] eff_trip;
  logic [`SCV_NVAR-1:0]              var_coinc;
  logic                              auto_div_cond;
  // Channel test forces a whole channel, division test forces a division trip
  // and system test forces a scram; none of them touches the manual paths.
  wire  logic                        div_test   = test_sel == scv_pkg::SCV_TEST_DIV;
  wire  logic                        sys_test   = test_sel == scv_pkg::SCV_TEST_SYS;
  wire  logic                        chan_test  = test_sel == scv_pkg::SCV_TEST_CHAN;

  // Only the first bypass is honoured so a second bypass cannot weaken voting.
  logic [`SCV_NDIV-1:0] byp_eff;
  assign byp_eff = chan_bypass & (~chan_bypass + `SCV_NDIV'h1);

  // A lost channel reads as tripped on every variable; a bypassed one never trips.
  always_comb begin
    for (int d = 0; d < `SCV_NDIV; d++) begin
      if (byp_eff[d]) begin
        eff_trip[d] = '0;
      end else if (!chan_healthy[d]) begin
        eff_trip[d] = '1;
      end else begin
        eff_trip[d] = chan_trip[d] | ({`SCV_NVAR{chan_test & test_inject[d]}});
      end
    end
    for (int v = 0; v < `SCV_NVAR; v++) begin
      logic [`SCV_NDIV-1:0] col;
      col = '0;
      for (int d = 0; d < `SCV_NDIV; d++) begin
        col[d] = eff_trip[d][v];
      end
      // Two of the remaining three with one bypass, else two of four.
      var_coinc[v] = scv_vote(col) & var_permit[v];
    end
    auto_div_cond = |var_coinc;
  end

  // All divisions share the one automatic vote; out-of-service divisions stay untripped.
  logic [`SCV_NDIV-1:0] div_cond;
  assign div_cond = ({`SCV_NDIV{auto_div_cond}} | ({`SCV_NDIV{div_test}} & test_inject)) & ~div_oos;

  // Sealed division trips still count, so two divisions tripping apart still scram.
  wire logic auto_full = scv_vote(div_trip_ff | (div_cond & ~div_oos));
  wire logic sys_full  = sys_test & (|test_inject);

  // ********************************************************************
  // Manual paths, fully separate from automatic voting
  // ********************************************************************
  // The manual terms read only the switches and the mode selector, never the vote.
  wire logic shutdown_pos = mode_sel == scv_pkg::SCV_MODE_SHUTDOWN;
  wire logic man_cond     = (man_sw_a & man_sw_b) | shutdown_pos;

  // ********************************************************************
  // Seal-in and delayed reset
  // ********************************************************************
  // The state machine only gates the operator reset; the trip outputs are held
  // by their own seal-in terms below.
  scv_pkg::scv_state_t     st_ff;
  scv_pkg::scv_state_t     nxt_st;
  logic [`SCV_CNT_W-1:0]   cnt_ff;
  logic [`SCV_CNT_W-1:0]   nxt_cnt;
  logic                    full_ff;

  wire logic full_now   = auto_full | sys_full | man_cond;
  // Only live causes refuse a reset; the sealed trips must not block their own clearing.
  wire logic cause_now  = scv_vote(div_cond) | sys_full | man_cond;
  wire logic reset_take = (st_ff == scv_pkg::SCV_ST_RESETOK) & oper_reset & ~cause_now;
  // The counter starts at the sealing edge, so the delay runs from the scram itself.
  wire logic cnt_done   = cnt_ff >= `SCV_CNT_W'(`SCV_RESET_CYC - 1);

  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      scv_pkg::SCV_ST_NORMAL: begin
        nxt_cnt = '0;
        if (full_now) begin
          nxt_st = scv_pkg::SCV_ST_SEALED;
        end
      end
      scv_pkg::SCV_ST_SEALED: begin
        nxt_cnt = cnt_ff + `SCV_CNT_W'h1;
        if (cnt_done) begin
          nxt_st = scv_pkg::SCV_ST_RESETOK;
        end
      end
      scv_pkg::SCV_ST_RESETOK: begin
        if (reset_take) begin
          nxt_st = scv_pkg::SCV_ST_NORMAL;
        end
      end
      default: begin
        nxt_st = scv_pkg::SCV_ST_SEALED;
      end
    endcase
  end

  // Once set, the scram term drops only on an accepted reset.
  wire logic nxt_full = (full_now | full_ff) & ~reset_take;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff          <= scv_pkg::SCV_ST_NORMAL;
      cnt_ff         <= '0;
      full_ff        <= 1'b0;
      div_trip_ff    <= '0;
      man_path_a_ff  <= 1'b0;
      man_path_b_ff  <= 1'b0;
    end else begin
      st_ff          <= nxt_st;
      cnt_ff         <= nxt_cnt;
      full_ff        <= nxt_full;
      div_trip_ff    <= div_cond | (div_trip_ff & ~{`SCV_NDIV{reset_take}});
      man_path_a_ff  <= man_cond | (man_path_a_ff & ~reset_take);
      man_path_b_ff  <= man_cond | (man_path_b_ff & ~reset_take);
    end
  end

  // ********************************************************************
  // Actuator and isolated status outputs
  // ********************************************************************
  // Every actuator follows the one sealed scram term, so run-in, both dump valves
  // and both solenoid drives always change on the same edge.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sol_a_energ_ff  <= 1'b1;
      sol_b_energ_ff  <= 1'b1;
      dump_valve_a_ff <= 1'b0;
      dump_valve_b_ff <= 1'b0;
      rod_runin_ff    <= 1'b0;
      status_ff       <= '0;
    end else begin
      sol_a_energ_ff  <= ~nxt_full;
      sol_b_energ_ff  <= ~nxt_full;
      dump_valve_a_ff <= nxt_full;
      dump_valve_b_ff <= nxt_full;
      rod_runin_ff    <= nxt_full;
      // Status is a registered copy that nothing in the trip path reads.
      status_ff.div_trip   <= div_trip_ff;
      status_ff.man_a      <= man_path_a_ff;
      status_ff.man_b      <= man_path_b_ff;
      status_ff.full_scram <= full_ff;
      status_ff.reset_ok   <= st_ff == scv_pkg::SCV_ST_RESETOK;
      // The test selection is echoed so that indication shows a test in force.
      status_ff.test_mode  <= test_sel;
      status_ff.spare      <= '0;
    end
  end

endmodule

//--- testbench/scv_voter_properties.sv
// Assertions on the coincidence voter outputs.
// Bound to scv_voter; sees its ports only.
`timescale 1ns/100ps
`include "scv_params.svh"
module scv_voter_properties (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic [3:0]         mode_sel,
  input wire logic               man_sw_a,
  input wire logic               man_sw_b,
  input wire logic [3:0]         div_trip_ff,
  input wire logic               sol_a_energ_ff,
  input wire logic               sol_b_energ_ff,
  input wire logic               dump_valve_a_ff,
  input wire logic               dump_valve_b_ff,
  input wire logic               rod_runin_ff,
  input wire logic               man_path_a_ff,
  input wire logic               man_path_b_ff,
  input wire scv_pkg::scv_stat_t status_ff
);
  localparam int DLY = `SCV_RESET_CYC;
  int sc_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Counts the cycles that a full scram has stood.
  always_ff @(posedge clk) begin
    if (!rstn || !rod_runin_ff) sc_ff <= 0;
    else sc_ff <= sc_ff + 1;
  end
  property p_sol; {sol_a_energ_ff, sol_b_energ_ff} == {2{!rod_runin_ff}}; endproperty
  a_sol: assert property (p_sol) else $error("solenoids disagree with full scram");
  property p_dump; {dump_valve_a_ff, dump_valve_b_ff} == {2{rod_runin_ff}}; endproperty
  a_dump: assert property (p_dump) else $error("dump valves disagree with run-in");
  property p_vote; $countones(div_trip_ff) >= 2 |-> rod_runin_ff; endproperty
  a_vote: assert property (p_vote) else $error("two divisions tripped without scram");
  property p_man; man_sw_a && man_sw_b |=> man_path_a_ff && man_path_b_ff; endproperty
  a_man: assert property (p_man) else $error("manual switches did not trip");
  property p_mode; mode_sel == scv_pkg::SCV_MODE_SHUTDOWN |=> man_path_a_ff && man_path_b_ff; endproperty
  a_mode: assert property (p_mode) else $error("shutdown mode did not trip");
  property p_seal; $rose(rod_runin_ff) |-> rod_runin_ff [*8]; endproperty
  a_seal: assert property (p_seal) else $error("full scram did not seal in");
  property p_delay; $fell(rod_runin_ff) && $past(rstn) |-> sc_ff >= DLY; endproperty
  a_delay: assert property (p_delay) else $error("scram cleared too early");
  property p_stat; $past(rstn) |-> status_ff.full_scram == $past(rod_runin_ff)
    && status_ff.div_trip == $past(div_trip_ff) && status_ff.spare == 6'h00
    && status_ff.man_a == $past(man_path_a_ff) && status_ff.man_b == $past(man_path_b_ff); endproperty
  a_stat: assert property (p_stat) else $error("status does not follow outputs");
endmodule
bind scv_voter scv_voter_properties u_props (.clk(clk), .rstn(rstn), .mode_sel(mode_sel), .man_sw_a(man_sw_a),
  .man_sw_b(man_sw_b), .div_trip_ff(div_trip_ff), .sol_a_energ_ff(sol_a_energ_ff), .sol_b_energ_ff(sol_b_energ_ff),
  .dump_valve_a_ff(dump_valve_a_ff), .dump_valve_b_ff(dump_valve_b_ff), .rod_runin_ff(rod_runin_ff),
  .man_path_a_ff(man_path_a_ff), .man_path_b_ff(man_path_b_ff), .status_ff(status_ff));

//--- testbench/scv_chan_model.sv
// Instrument channels feeding the voter.
// Driven by the bench; a lost channel shows a toggling pattern.
`timescale 1ns/100ps
module scv_chan_model (
  input  wire logic                    clk,
  input  wire scv_pkg::scv_var_t [3:0] trip_req,
  input  wire logic [3:0]              lost,
  output scv_pkg::scv_var_t [3:0]      chan_trip,
  output logic [3:0]                   chan_healthy
);
  scv_pkg::scv_var_t junk = 8'h5A;
  always @(posedge clk) junk <= ~junk;
  // A disconnected channel carries no valid trip data.
  always_comb for (int d = 0; d < 4; d++) chan_trip[d] = lost[d] ? junk : trip_req[d];
  assign chan_healthy = ~lost;
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the coincidence voter.
// Uses scv_chan_model on the channel side; the checker is bound.
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rstn = 0, man_sw_a = 0, man_sw_b = 0, oper_reset = 0;
  scv_pkg::scv_var_t [3:0] trip_req = '0, chan_trip;
  scv_pkg::scv_var_t var_permit = 8'hFF;
  logic [3:0] lost = 4'h0, chan_healthy, chan_bypass = 4'h0, div_oos = 4'h0, mode_sel = 4'h8, div_trip_ff, e, tinj = 4'h0;
  logic [1:0] tsel = 2'h0;
  logic sol_a, sol_b, dmp_a, dmp_b, runin, man_a, man_b;
  logic [31:0] seed = 32'h6BA2;
  int num_errors = 0, cmp_count = 0, cyc = 0, i;
  wire logic [8:0] outs = {div_trip_ff, sol_a, sol_b, dmp_a, dmp_b, runin};
  always #5 clk = ~clk;
  scv_chan_model chans (.clk(clk), .trip_req(trip_req), .lost(lost), .chan_trip(chan_trip), .chan_healthy(chan_healthy));
  scv_voter dut (.clk(clk), .rstn(rstn), .chan_trip(chan_trip), .chan_healthy(chan_healthy), .chan_bypass(chan_bypass),
    .div_oos(div_oos), .var_permit(var_permit), .mode_sel(mode_sel), .man_sw_a(man_sw_a), .man_sw_b(man_sw_b),
    .oper_reset(oper_reset), .test_sel(tsel), .test_inject(tinj), .div_trip_ff(div_trip_ff), .sol_a_energ_ff(sol_a),
    .sol_b_energ_ff(sol_b), .dump_valve_a_ff(dmp_a), .dump_valve_b_ff(dmp_b), .rod_runin_ff(runin),
    .man_path_a_ff(man_a), .man_path_b_ff(man_b), .status_ff());
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reference vote: any permitted variable with two unbypassed channels tripping or lost trips every division in service.
  function automatic logic [3:0] exp_div();
    int byp, cnt, hit;
    byp = -1;
    hit = 0;
    for (int d = 3; d >= 0; d--) if (chan_bypass[d]) byp = d;
    for (int v = 0; v < 8; v++) begin
      cnt = 0;
      for (int d = 0; d < 4; d++) if (d != byp && (trip_req[d][v] || lost[d] || (tsel == 2'h1 && tinj[d]))) cnt++;
      if (cnt >= 2 && var_permit[v]) hit = 1;
    end
    return (hit ? ~div_oos : 4'h0) | (tsel == 2'h2 ? tinj & ~div_oos : 4'h0);
  endfunction
  function automatic logic [8:0] expv(logic [3:0] dv, logic f);
    return {dv, !f, !f, f, f, f};
  endfunction
  task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rst();
    {trip_req, lost, chan_bypass, div_oos, tinj, tsel, man_sw_a, man_sw_b} = '0;
    {var_permit, mode_sel, rstn} = {8'hFF, 4'h8, 1'b0};
    repeat (5) @(negedge clk);
    rstn = 1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst();
    chk("reset state", expv(4'h0, 0), outs);
    for (i = 0; i < 24; i++) begin
      for (int d = 0; d < 4; d++) trip_req[d] = 8'(rnd() & rnd() & rnd());
      {lost, div_oos} = {4'(rnd() & rnd() & rnd()), 4'(rnd() & rnd())};
      {chan_bypass, var_permit} = {4'(32'h1 << (rnd() % 5)), 8'(rnd() | rnd())};
      {tsel, tinj} = 6'(rnd());
      e = exp_div();
      @(negedge clk);
      chk("vote outputs", expv(e, $countones(e) >= 2 || (tsel == 2'h3 && tinj != 4'h0)), outs);
      rst();
    end
    $display("vote test done");
    for (i = 0; i < 5; i++) begin
      {man_sw_a, man_sw_b} = 2'(i);
      mode_sel = (i == 4) ? 4'h1 : 4'h8;
      @(negedge clk);
      chk("manual paths", {7'h00, {2{i >= 3}}}, {7'h00, man_a, man_b});
      chk("manual scram", expv(4'h0, i >= 3), outs);
      rst();
    end
    $display("manual test done");
    {trip_req[0], trip_req[1]} = 16'h0101;
    @(negedge clk);
    trip_req = '0;
    repeat (100) @(negedge clk);
    oper_reset = 1;
    @(negedge clk);
    oper_reset = 0;
    chk("early reset", expv(4'hF, 1), outs);
    repeat (120) @(negedge clk);
    oper_reset = 1;
    @(negedge clk);
    oper_reset = 0;
    chk("late reset", expv(4'h0, 0), outs);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
